// file: simd_alu.sv
`timescale 1ns/100ps

module simd_alu (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic issue_valid,
  input wire simd_alu_pkg::alu_op_t op,
  input wire logic condition_passed,
  input wire logic [31:0] first_operand,
  input wire logic [31:0] second_operand,
  input wire logic [3:0] first_operand_register,
  input wire logic [3:0] second_operand_register,
  input wire logic dest_given,
  input wire logic [3:0] dest_register,
  output logic write_valid,
  output logic [3:0] write_register,
  output logic [31:0] write_data,
  output logic flags_valid,
  output logic [3:0] greater_equal_flags
);

  // ****************************************************************
  // Lane arithmetic
  // ****************************************************************
  logic [3:0] lane_sub; // Per byte lane: subtract instead of add
  logic [3:0] lane_cin; // Per byte lane: carry into lane
  logic [3:0] lane_cout; // Per byte lane: carry out of lane
  logic [31:0] lane_b; // Second operand, exchanged when asked
  logic [31:0] raw; // Low bits of each lane result
  logic is_half; // Halfword lanes chain byte pairs
  logic is_xchg; // Exchange forms
  logic is_halving; // Halving forms

  // Operation decode and operand exchange
  always_comb begin
    is_xchg = op inside {simd_alu_pkg::exchange_add_subtract,
      simd_alu_pkg::exchange_subtract_add,
      simd_alu_pkg::halving_exchange_add_subtract,
      simd_alu_pkg::halving_exchange_subtract_add};
    is_halving = op inside {simd_alu_pkg::halving_halfword_add,
      simd_alu_pkg::halving_byte_add,
      simd_alu_pkg::halving_exchange_add_subtract,
      simd_alu_pkg::halving_exchange_subtract_add};
    is_half = !(op inside {simd_alu_pkg::packed_byte_add,
      simd_alu_pkg::halving_byte_add});
    // Exchange forms pair first low with second high and back
    lane_b = is_xchg ? {second_operand[15:0], second_operand[31:16]}
                     : second_operand;
    lane_sub = 4'h0;
    if (op inside {simd_alu_pkg::exchange_add_subtract,
        simd_alu_pkg::halving_exchange_add_subtract}) begin
      lane_sub = 4'h3; // Low half subtracts
    end else if (op inside {simd_alu_pkg::exchange_subtract_add,
        simd_alu_pkg::halving_exchange_subtract_add}) begin
      lane_sub = 4'hC; // High half subtracts
    end
  end

  // Byte lanes; odd lanes take carry from even ones only in halfwords
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      if (g % 2 == 0) begin : g_even
        assign lane_cin[g] = lane_sub[g];
      end else begin : g_odd
        assign lane_cin[g] = is_half ? lane_cout[g-1] : 1'b0;
      end
      lane_adder u_lane (
        .a(first_operand[g*8 +: 8]),
        .b(lane_b[g*8 +: 8]),
        .carry_in(lane_cin[g]),
        .subtract(lane_sub[g]),
        .result(raw[g*8 +: 8]),
        .carry_out(lane_cout[g])
      );
    end
  endgenerate

  // ****************************************************************
  // Result and flags
  // ****************************************************************
  logic [3:0] top_bit; // Ninth or seventeenth bit of each lane result
  logic [31:0] halved; // Each lane shifted right by one
  logic [3:0] lane_ge; // Flag value per byte lane
  logic [31:0] result; // Final data for this operation

  // Top bit: carry for sums, not-borrow inverted gives the sign
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      top_bit[i] = lane_sub[i] ? ~lane_cout[i] : lane_cout[i];
      // Sum reaches the lane range, or difference is non-negative
      // Carry out of an add equals no borrow out of a subtract
      lane_ge[i] = lane_cout[i];
    end
    if (is_half) begin
      // Both flags of a halfword follow its upper byte
      lane_ge = {{2{lane_ge[3]}}, {2{lane_ge[1]}}};
      halved = {top_bit[3], raw[31:17], top_bit[1], raw[15:1]};
    end else begin
      halved = {top_bit[3], raw[31:25], top_bit[2], raw[23:17],
                top_bit[1], raw[15:9], top_bit[0], raw[7:1]};
    end
    result = is_halving ? halved : raw;
  end

  // ****************************************************************
  // Write-back stage
  // ****************************************************************
  logic next_write_valid;
  logic [3:0] next_write_register;
  logic [31:0] next_write_data;
  logic next_flags_valid;
  logic [3:0] next_flags;
  logic commit; // Issued and condition passed

  // Next values; data and register hold unless issued with the condition passed; flags also hold on halving forms
  always_comb begin
    commit = issue_valid && condition_passed;
    next_write_valid = commit;
    next_write_register = write_register;
    next_write_data = write_data;
    next_flags_valid = commit && !is_halving;
    next_flags = greater_equal_flags;
    if (commit) begin
      next_write_data = result;
      // Missing destination falls back to first operand register
      next_write_register = dest_given ? dest_register
                                       : first_operand_register;
      if (!is_halving) begin
        next_flags = lane_ge;
      end
    end
  end

  // Registers only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      write_valid <= 1'b0;
      write_register <= 4'h0;
      write_data <= simd_alu_pkg::RESULT_RESET;
      flags_valid <= 1'b0;
      greater_equal_flags <= simd_alu_pkg::FLAGS_RESET;
    end else begin
      write_valid <= next_write_valid;
      write_register <= next_write_register;
      write_data <= next_write_data;
      flags_valid <= next_flags_valid;
      greater_equal_flags <= next_flags;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  halfword_sum_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    issue_valid && condition_passed && op == simd_alu_pkg::packed_halfword_add
    |=> write_data[15:0] == 16'($past(first_operand[15:0])
      + $past(second_operand[15:0])))
    else $error("halfword add low lane wrong");
  byte_sum_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    issue_valid && condition_passed && op == simd_alu_pkg::packed_byte_add
    |=> write_data[15:8] == 8'($past(first_operand[15:8])
      + $past(second_operand[15:8])))
    else $error("byte add lane one wrong");
  dest_default_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    issue_valid && condition_passed && !dest_given
    |=> write_valid && write_register == $past(first_operand_register))
    else $error("default destination wrong");
  add_flags_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    issue_valid && condition_passed && op == simd_alu_pkg::packed_halfword_add
    |=> greater_equal_flags[1:0] == (({1'b0, $past(first_operand[15:0])}
      + {1'b0, $past(second_operand[15:0])}) >= 17'h10000 ? 2'h3 : 2'h0))
    else $error("halfword flags wrong");
  xchg_high_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    issue_valid && condition_passed
    && op == simd_alu_pkg::exchange_add_subtract
    |=> write_data[31:16] == 16'($past(first_operand[31:16])
      + $past(second_operand[15:0])))
    else $error("add-subtract high lane wrong");
  xchg_flags_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    issue_valid && condition_passed
    && op == simd_alu_pkg::exchange_subtract_add
    |=> greater_equal_flags[3:2] == ($past(first_operand[31:16])
      >= $past(second_operand[15:0]) ? 2'h3 : 2'h0))
    else $error("subtract-add flags wrong");
  halving_flags_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    issue_valid && is_halving |=> $stable(greater_equal_flags) && !flags_valid)
    else $error("halving changed flags");
  halving_sign_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    issue_valid && condition_passed
    && op == simd_alu_pkg::halving_exchange_subtract_add
    |=> write_data[31] == ($past(first_operand[31:16])
      < $past(second_operand[15:0])))
    else $error("halved difference sign wrong");
  cond_fail_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    !(issue_valid && condition_passed) |=> !write_valid
    && $stable(write_data) && $stable(greater_equal_flags))
    else $error("state changed on failed condition");
  // Halved sums keep their carry as the top bit of each lane
  halving_half_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    issue_valid && condition_passed && op == simd_alu_pkg::halving_halfword_add
    |=> write_data[31:16] == 16'(({1'b0, $past(first_operand[31:16])}
      + {1'b0, $past(second_operand[31:16])}) >> 1))
    else $error("halving halfword high lane wrong");
  halving_byte_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    issue_valid && condition_passed && op == simd_alu_pkg::halving_byte_add
    |=> write_data[7:0] == 8'(({1'b0, $past(first_operand[7:0])}
      + {1'b0, $past(second_operand[7:0])}) >> 1))
    else $error("halving byte low lane wrong");
  // A 17-bit difference wraps, so its shift keeps the sign on top
  halving_diff_a: assert property (
    @(posedge core_clk) disable iff (!reset_n)
    issue_valid && condition_passed
    && op == simd_alu_pkg::halving_exchange_add_subtract
    |=> write_data[15:0] == 16'(({1'b0, $past(first_operand[15:0])}
      - {1'b0, $past(second_operand[31:16])}) >> 1))
    else $error("halving difference low lane wrong");

endmodule : simd_alu

// file: simd_alu_pkg.sv
package simd_alu_pkg;

  // ****************************************************************
  // Operation codes
  // ****************************************************************
  typedef enum logic [7:0] {
    packed_halfword_add = 8'h01,
    packed_byte_add = 8'h02,
    exchange_add_subtract = 8'h04,
    exchange_subtract_add = 8'h08,
    halving_halfword_add = 8'h10,
    halving_byte_add = 8'h20,
    halving_exchange_add_subtract = 8'h40,
    halving_exchange_subtract_add = 8'h80
  } alu_op_t;

  // ****************************************************************
  // Widths and lane layout
  // ****************************************************************
  localparam int unsigned WORD_W = 32;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned LANES = 4;
  localparam int unsigned REG_IDX_W = 4;
  localparam logic [3:0] STACK_POINTER_IDX = 4'hD;
  localparam logic [3:0] PROGRAM_COUNTER_IDX = 4'hF;
  localparam logic [31:0] RESULT_RESET = 32'h00000000;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

endpackage : simd_alu_pkg

// file: lane_adder.sv
`timescale 1ns/100ps

// ****************************************************************
// One byte lane: 9-bit add or subtract with carry or borrow out
// ****************************************************************
module lane_adder (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  input wire logic carry_in,
  input wire logic subtract,
  output logic [7:0] result,
  output logic carry_out
);

  // Subtraction is a plus inverted b with carry in set by the caller
  logic [8:0] full;
  always_comb begin
    full = {1'b0, a} + {1'b0, (subtract ? ~b : b)} + {8'h00, carry_in};
    result = full[7:0];
    carry_out = full[8];
  end

endmodule : lane_adder

// file: operand_file.sv
`timescale 1ns/100ps

// ****************************************************************
// Register file model feeding operands and taking write-back
// ****************************************************************
module operand_file (
  input wire logic core_clk,
  input wire logic write_valid,
  input wire logic [3:0] write_register,
  input wire logic [31:0] write_data,
  input wire logic [3:0] first_operand_register,
  input wire logic [3:0] second_operand_register,
  output logic [31:0] first_operand,
  output logic [31:0] second_operand
);
  logic [31:0] regs [16]; // General registers, preloaded by the bench

  // Known contents from time zero
  initial begin
    for (int i = 0; i < 16; i++) begin
      regs[i] = 32'h00000000;
    end
  end

  // Operand read ports
  assign first_operand = regs[first_operand_register];
  assign second_operand = regs[second_operand_register];

  // Commit a result into the named register
  always @(posedge core_clk) begin
    if (write_valid) begin
      regs[write_register] <= write_data;
    end
  end
endmodule : operand_file

// file: tb.sv
`timescale 1ns/100ps

module tb;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic issue_valid = 1'b0;
  simd_alu_pkg::alu_op_t op = simd_alu_pkg::packed_halfword_add;
  logic condition_passed = 1'b0;
  logic [31:0] first_operand;
  logic [31:0] second_operand;
  logic [3:0] first_operand_register = 4'h1; // Not 4'hD or 4'hF
  logic [3:0] second_operand_register = 4'h2;
  logic dest_given = 1'b0;
  logic [3:0] dest_register = 4'h3;
  logic write_valid;
  logic flags_valid;
  logic [3:0] write_register;
  logic [3:0] greater_equal_flags;
  logic [31:0] write_data;
  int n_errors = 0;
  int samples_checked = 0;
  logic [31:0] exp_r; // Expected result
  logic [3:0] exp_g; // Expected flags
  logic [31:0] old_r; // Result before the operation
  logic [3:0] old_g; // Flags before the operation
  logic [3:0] exp_f; // Flags expected after the operation

  always #10 core_clk = ~core_clk;

  simd_alu simd_alu_i (.core_clk(core_clk), .reset_n(reset_n),
    .issue_valid(issue_valid), .op(op), .condition_passed(condition_passed),
    .first_operand(first_operand), .second_operand(second_operand),
    .first_operand_register(first_operand_register),
    .second_operand_register(second_operand_register),
    .dest_given(dest_given), .dest_register(dest_register),
    .write_valid(write_valid), .write_register(write_register),
    .write_data(write_data), .flags_valid(flags_valid),
    .greater_equal_flags(greater_equal_flags));

  operand_file operand_file_i (.core_clk(core_clk), .write_valid(write_valid),
    .write_register(write_register), .write_data(write_data),
    .first_operand_register(first_operand_register),
    .second_operand_register(second_operand_register),
    .first_operand(first_operand), .second_operand(second_operand));

  // ****************************************************************
  // Reference arithmetic and helpers
  // ****************************************************************
  function automatic void ref_op(input logic [7:0] o, input logic [31:0] a,
      input logic [31:0] b, output logic [31:0] r, output logic [3:0] g);
    logic [16:0] lo;
    logic [16:0] hi;
    logic [8:0] y;
    logic h;
    h = |o[7:4];
    if (o[1] | o[5]) begin
      for (int i = 0; i < 4; i++) begin
        y = a[8*i+:8] + b[8*i+:8];
        r[8*i+:8] = h ? y[8:1] : y[7:0];
        g[i] = y[8];
      end
    end else begin
      lo = (o[2] | o[6]) ? a[15:0] - b[31:16] :
           (o[3] | o[7]) ? a[15:0] + b[31:16] : a[15:0] + b[15:0];
      hi = (o[3] | o[7]) ? a[31:16] - b[15:0] :
           (o[2] | o[6]) ? a[31:16] + b[15:0] : a[31:16] + b[31:16];
      r = h ? {hi[16:1], lo[16:1]} : {hi[15:0], lo[15:0]};
      g[1:0] = {2{lo[16] ^ (o[2] | o[6])}};
      g[3:2] = {2{hi[16] ^ (o[3] | o[7])}};
    end
  endfunction : ref_op

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Offer one operation; returns once its answer is visible
  task automatic issue(input int i, input logic [31:0] a, input logic [31:0] b,
      input logic cond, input logic dg);
    @(negedge core_clk);
    operand_file_i.regs[1] = a;
    operand_file_i.regs[2] = b;
    op = simd_alu_pkg::alu_op_t'(8'h01 << i);
    condition_passed = cond;
    dest_given = dg;
    issue_valid = 1'b1;
    old_r = write_data;
    old_g = greater_equal_flags;
    ref_op(8'h01 << i, a, b, exp_r, exp_g);
    @(negedge core_clk);
    issue_valid = 1'b0;
  endtask : issue

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Every operation on two operand sets, one with halfword-add carries, one without
  task automatic test_ops;
    logic [31:0] a;
    logic [31:0] b;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        a = p ? 32'hFFFF80FF : 32'h12340001;
        b = p ? 32'h00018001 : 32'h80000FFF;
        issue(i, a, b, 1'b1, 1'b1);
        exp_f = (i < 4) ? exp_g : old_g;
        chk({31'h0, write_valid}, 32'h00000001);
        chk(write_data, exp_r);
        chk(write_data, exp_r);
        chk(write_data, exp_r);
        chk({28'h0, write_register}, 32'h00000003);
        chk({31'h0, flags_valid}, {31'h0, i < 4});
        chk({28'h0, greater_equal_flags}, {28'h0, exp_f});
      end
    end
    $display("test_ops done");
  endtask : test_ops

  // Failed condition: nothing written, nothing flagged
  task automatic test_cond;
    issue(0, 32'hFFFFFFFF, 32'h00010001, 1'b0, 1'b1);
    chk({30'h0, write_valid, flags_valid}, 32'h00000000);
    chk(write_data, old_r);
    chk({28'h0, greater_equal_flags}, {28'h0, old_g});
    $display("test_cond done");
  endtask : test_cond

  // No destination named: result lands in the first operand register
  task automatic test_dest;
    issue(1, 32'h01020304, 32'h01010101, 1'b1, 1'b0);
    chk({28'h0, write_register}, 32'h00000001);
    @(negedge core_clk);
    chk(operand_file_i.regs[1], exp_r);
    $display("test_dest done");
  endtask : test_dest

  // Mid-run reset clears every output, which stays clear after release
  task automatic test_reset;
    @(negedge core_clk);
    reset_n = 1'b0;
    @(negedge core_clk);
    exp_r = simd_alu_pkg::RESULT_RESET;
    exp_f = simd_alu_pkg::FLAGS_RESET;
    chk(write_data, exp_r);
    chk({28'h0, greater_equal_flags}, {28'h0, exp_f});
    chk({26'h0, write_valid, flags_valid, write_register}, 32'h0);
    reset_n = 1'b1;
    @(negedge core_clk);
    chk({30'h0, write_valid, flags_valid}, 32'h00000000);
    chk(write_data, exp_r);
    chk({28'h0, greater_equal_flags}, {28'h0, exp_f});
    $display("test_reset done");
  endtask : test_reset

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog sized well beyond the expected run
  initial begin
    #(20 * 5000);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end

  // Main sequence
  initial begin
    repeat (12) @(negedge core_clk);
    reset_n = 1'b1;
    test_ops();
    test_cond();
    test_dest();
    test_reset();
    report_and_stop();
  end
endmodule : tb
